//--- hdl/dtc_pin_in.sv
`timescale 1ns/1ps
module dtc_pin_in (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pin,
	input wire logic sample_tick,
	output logic level,
	output logic fall
);
	typedef struct packed {
		logic sync1;
		logic sync2;
		logic smp;
		logic fall;
	} dtc_pin_state_t;

	dtc_pin_state_t st_ff;
	dtc_pin_state_t nxt_st;

	////////////////////////////////////////////////////////////////
	// Synchroniser and sampled edge detect
	always_comb begin
		nxt_st = st_ff;
		nxt_st.sync1 = pin;
		nxt_st.sync2 = st_ff.sync1;
		nxt_st.fall = 1'b0;
		if (sample_tick) begin
			nxt_st.smp = st_ff.sync2;
			nxt_st.fall = st_ff.smp && !st_ff.sync2;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign level = st_ff.smp;
	assign fall = st_ff.fall;
endmodule // dtc_pin_in

//--- hdl/dtc_pkg.sv
// Notes on behaviour
// - Base tick is oscillator divided by 4, 16 or 64; code 11 reserved; reset divide-by-4.
// - With external qualify set, timer advances only while its interrupt pin high and run set.
// - Count source clear counts prescaled clock; set counts event pin pulses.
// - Mode 00 16-bit reload, 01 16-bit free, 10 8-bit reload, 11 split (timer 0).
// - Each timer has a high and a low 8-bit reload register, four in all.
// - 16-bit reload mode sets overflow flag when the high count byte overflows.
// - That overflow loads low and high count bytes from low and high reload registers.
// - 8-bit reload mode reloads the low byte from the low reload register.
// - 16-bit reload overflow interval is divisor times (65536 minus reload) oscillator cycles.
// - Configuration and mode registers reset to zero.
// - Counter mode counts falling edges of event pin, sampled every 2 oscillator cycles.
// - 8-bit reload mode sets flag on low byte overflow and leaves high byte unchanged.
// - Timer 1 in the split mode code holds its count as if stopped.
package dtc_pkg;
	localparam logic [11:0] ADDR_TIMER_CTRL = 12'h410;
	localparam logic [11:0] ADDR_SYS_CFG = 12'h440;
	localparam logic [11:0] ADDR_TIMER_MODE = 12'h45C;
	localparam logic [11:0] ADDR_CNT0_LO = 12'h460;
	localparam logic [11:0] ADDR_CNT0_HI = 12'h464;
	localparam logic [11:0] ADDR_CNT1_LO = 12'h468;
	localparam logic [11:0] ADDR_CNT1_HI = 12'h46C;
	localparam logic [11:0] ADDR_RLD0_LO = 12'h470;
	localparam logic [11:0] ADDR_RLD0_HI = 12'h474;
	localparam logic [11:0] ADDR_RLD1_LO = 12'h478;
	localparam logic [11:0] ADDR_RLD1_HI = 12'h47C;
	localparam logic [7:0] SYS_CFG_RESET = 8'h00;
	localparam logic [7:0] TIMER_MODE_RESET = 8'h00;
	localparam logic [7:0] TIMER_CTRL_RESET = 8'h00;
	localparam logic [7:0] SYS_CFG_MASK = 8'h0F;
	localparam int PRESCALE_LSB = 2;
	localparam int TIMER_MODE_REG_STRIDE = 4;
	localparam int TIMER_MODE_REG_GATE_BIT = 3;
	localparam int TIMER_MODE_REG_CT_BIT = 2;
	localparam int TCTRL_RUN0_BIT = 4;
	localparam int TCTRL_FLAG0_BIT = 5;
	localparam int TCTRL_RUN1_BIT = 6;
	localparam int TCTRL_FLAG1_BIT = 7;
	localparam logic [5:0] DIV4_LAST = 6'h03;
	localparam logic [5:0] DIV16_LAST = 6'h0F;
	localparam logic [5:0] DIV64_LAST = 6'h3F;
	localparam int EVENT_SAMPLE_NS = 10;
	localparam int CLK_PERIOD_NS = 5;
	localparam int EVENT_SAMPLE_CYC = (EVENT_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0] PS_DIV4 = 2'b00;
	localparam logic [1:0] PS_DIV16 = 2'b01;
	localparam logic [1:0] PS_DIV64 = 2'b10;
	localparam logic [1:0] MODE_16_RELOAD = 2'b00;
	localparam logic [1:0] MODE_16_FREE = 2'b01;
	localparam logic [1:0] MODE_8_RELOAD = 2'b10;
	localparam logic [1:0] MODE_SPLIT = 2'b11;

	typedef enum {
		DTC_REG_NONE, DTC_REG_TCTRL, DTC_REG_SCFG, DTC_REG_TMODE,
		DTC_REG_CNT_LO, DTC_REG_CNT_HI, DTC_REG_RLD_LO, DTC_REG_RLD_HI
	} dtc_reg_t;
endpackage

//--- hdl/dtc_prescaler.sv
`timescale 1ns/1ps
module dtc_prescaler (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [1:0] prescale_sel,
	output logic base_tick,
	output logic sample_tick
);
	import dtc_pkg::*;

	typedef struct packed {
		logic [5:0] div_cnt;
		logic [5:0] samp_cnt;
		logic base;
		logic samp;
	} dtc_ps_state_t;

	dtc_ps_state_t st_ff;
	dtc_ps_state_t nxt_st;
	logic [5:0] last;
	logic valid;

	////////////////////////////////////////////////////////////////
	// Divider
	always_comb begin
		valid = 1'b1;
		last = DIV4_LAST;
		case (prescale_sel)
			PS_DIV4: last = DIV4_LAST;
			PS_DIV16: last = DIV16_LAST;
			PS_DIV64: last = DIV64_LAST;
			default: valid = 1'b0;
		endcase
		nxt_st = st_ff;
		nxt_st.base = 1'b0;
		if (!valid || st_ff.div_cnt >= last) begin
			nxt_st.div_cnt = 6'h00;
			nxt_st.base = valid;
		end else begin
			nxt_st.div_cnt = st_ff.div_cnt + 6'h01;
		end
		nxt_st.samp = 1'b0;
		if (st_ff.samp_cnt >= 6'(EVENT_SAMPLE_CYC - 1)) begin
			nxt_st.samp_cnt = 6'h00;
			nxt_st.samp = 1'b1;
		end else begin
			nxt_st.samp_cnt = st_ff.samp_cnt + 6'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign base_tick = st_ff.base;
	assign sample_tick = st_ff.samp;
endmodule // dtc_prescaler

//--- hdl/dtc_top.sv
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
module dtc_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [1:0] event_input_pin,
	input wire logic [1:0] ext_int_pin,
	output logic [1:0] overflow_flag
);
	import dtc_pkg::*;

	typedef struct packed {
		logic [7:0] sys_cfg;
		logic [7:0] tmode;
		logic [1:0] run_bit;
		logic [1:0] flag;
		logic [1:0][7:0] count_low_byte;
		logic [1:0][7:0] count_high_byte;
		logic [1:0][7:0] reload_low_byte;
		logic [1:0][7:0] reload_high_byte;
		logic [31:0] rdata;
		logic err;
	} dtc_state_t;

	dtc_state_t st_ff;
	dtc_state_t nxt_st;
	logic base_tick;
	logic sample_tick;
	logic [3:0] pins;
	logic [3:0] pin_lvl;
	logic [3:0] pin_fall;
	logic [1:0] int_lvl;
	logic [1:0] ev_fall;

	////////////////////////////////////////////////////////////////
	// Address decode
	function automatic dtc_reg_t decode(input logic [11:0] a);
		case (a)
			ADDR_TIMER_CTRL: decode = DTC_REG_TCTRL;
			ADDR_SYS_CFG: decode = DTC_REG_SCFG;
			ADDR_TIMER_MODE: decode = DTC_REG_TMODE;
			ADDR_CNT0_LO, ADDR_CNT1_LO: decode = DTC_REG_CNT_LO;
			ADDR_CNT0_HI, ADDR_CNT1_HI: decode = DTC_REG_CNT_HI;
			ADDR_RLD0_LO, ADDR_RLD1_LO: decode = DTC_REG_RLD_LO;
			ADDR_RLD0_HI, ADDR_RLD1_HI: decode = DTC_REG_RLD_HI;
			default: decode = DTC_REG_NONE;
		endcase
	endfunction

	// Timer selected by a per-timer address
	function automatic int unsigned timer_of(input logic [11:0] a);
		case (a)
			ADDR_CNT1_LO, ADDR_CNT1_HI, ADDR_RLD1_LO, ADDR_RLD1_HI: timer_of = 1;
			default: timer_of = 0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////
	// Clock divider and pins
	dtc_prescaler u_prescaler (
		.pclk(pclk),
		.presetn(presetn),
		.prescale_sel(st_ff.sys_cfg[PRESCALE_LSB +: 2]),
		.base_tick(base_tick),
		.sample_tick(sample_tick)
	);

	assign pins = {ext_int_pin, event_input_pin};

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_pin
			dtc_pin_in u_pin (
				.pclk(pclk),
				.presetn(presetn),
				.pin(pins[g]),
				.sample_tick(sample_tick),
				.level(pin_lvl[g]),
				.fall(pin_fall[g])
			);
		end
	endgenerate

	assign ev_fall = pin_fall[1:0];
	assign int_lvl = pin_lvl[3:2];

	////////////////////////////////////////////////////////////////
	// Counting, register access
	always_comb begin
		logic [1:0] mode;
		logic gate;
		logic ct;
		logic run;
		logic tick;
		logic [1:0] set_flag;
		logic [15:0] cnt16;
		logic split0;
		dtc_reg_t rsel;
		int unsigned ti;
		logic [7:0] rbyte;
		mode = 2'b00;
		gate = 1'b0;
		ct = 1'b0;
		run = 1'b0;
		tick = 1'b0;
		set_flag = 2'b00;
		cnt16 = 16'h0000;
		rbyte = 8'h00;
		nxt_st = st_ff;
		split0 = (st_ff.tmode[1:0] == MODE_SPLIT);
		rsel = decode(paddr);
		ti = timer_of(paddr);

		for (int n = 0; n < 2; n++) begin
			mode = st_ff.tmode[n * TIMER_MODE_REG_STRIDE +: 2];
			gate = st_ff.tmode[n * TIMER_MODE_REG_STRIDE + TIMER_MODE_REG_GATE_BIT];
			ct = st_ff.tmode[n * TIMER_MODE_REG_STRIDE + TIMER_MODE_REG_CT_BIT];
			run = st_ff.run_bit[n] && (!gate || int_lvl[n]);
			tick = run && (ct ? ev_fall[n] : base_tick);
			cnt16 = {st_ff.count_high_byte[n], st_ff.count_low_byte[n]};
			case (mode)
				MODE_16_RELOAD: begin
					if (tick) begin
						if (cnt16 == 16'hFFFF) begin
							set_flag[n] = 1'b1;
							nxt_st.count_low_byte[n] = st_ff.reload_low_byte[n];
							nxt_st.count_high_byte[n] = st_ff.reload_high_byte[n];
						end else begin
							{nxt_st.count_high_byte[n], nxt_st.count_low_byte[n]} = cnt16 + 16'h0001;
						end
					end
				end
				MODE_16_FREE: begin
					if (tick) begin
						{nxt_st.count_high_byte[n], nxt_st.count_low_byte[n]} = cnt16 + 16'h0001;
						if (cnt16 == 16'hFFFF) begin
							set_flag[n] = 1'b1;
						end
					end
				end
				MODE_8_RELOAD: begin
					if (tick) begin
						if (st_ff.count_low_byte[n] == 8'hFF) begin
							set_flag[n] = 1'b1;
							nxt_st.count_low_byte[n] = st_ff.reload_low_byte[n];
						end else begin
							nxt_st.count_low_byte[n] = st_ff.count_low_byte[n] + 8'h01;
						end
					end
				end
				default: begin
					if (n == 0) begin
						if (tick) begin
							nxt_st.count_low_byte[0] = st_ff.count_low_byte[0] + 8'h01;
							set_flag[0] = (st_ff.count_low_byte[0] == 8'hFF);
						end
						// High byte is a plain timer on the second run bit
						if (base_tick && st_ff.run_bit[1]) begin
							nxt_st.count_high_byte[0] = st_ff.count_high_byte[0] + 8'h01;
							set_flag[1] = (st_ff.count_high_byte[0] == 8'hFF);
						end
					end
					// Timer 1 holds in this mode code
				end
			endcase
		end
		// Flag 1 comes from the timer 0 high byte, not timer 1, while timer 0 owns it
		if (split0 && st_ff.tmode[TIMER_MODE_REG_STRIDE +: 2] != MODE_SPLIT) begin
			set_flag[1] = (st_ff.tmode[1:0] == MODE_SPLIT) && base_tick && st_ff.run_bit[1]
				&& (st_ff.count_high_byte[0] == 8'hFF);
		end

		// APB write in access phase
		if (psel && penable && pwrite) begin
			case (rsel)
				DTC_REG_TCTRL: begin
					nxt_st.run_bit[0] = pwdata[TCTRL_RUN0_BIT];
					nxt_st.run_bit[1] = pwdata[TCTRL_RUN1_BIT];
					nxt_st.flag[0] = pwdata[TCTRL_FLAG0_BIT];
					nxt_st.flag[1] = pwdata[TCTRL_FLAG1_BIT];
				end
				DTC_REG_SCFG: nxt_st.sys_cfg = pwdata[7:0] & SYS_CFG_MASK;
				DTC_REG_TMODE: nxt_st.tmode = pwdata[7:0];
				DTC_REG_CNT_LO: nxt_st.count_low_byte[ti] = pwdata[7:0];
				DTC_REG_CNT_HI: nxt_st.count_high_byte[ti] = pwdata[7:0];
				DTC_REG_RLD_LO: nxt_st.reload_low_byte[ti] = pwdata[7:0];
				DTC_REG_RLD_HI: nxt_st.reload_high_byte[ti] = pwdata[7:0];
				default: begin
				end
			endcase
		end
		// Hardware set wins over software clear
		nxt_st.flag = nxt_st.flag | set_flag;

		// Read data and error captured in setup phase
		if (psel && !penable) begin
			case (rsel)
				DTC_REG_TCTRL: begin
					rbyte = 8'h00;
					rbyte[TCTRL_RUN0_BIT] = st_ff.run_bit[0];
					rbyte[TCTRL_RUN1_BIT] = st_ff.run_bit[1];
					rbyte[TCTRL_FLAG0_BIT] = st_ff.flag[0];
					rbyte[TCTRL_FLAG1_BIT] = st_ff.flag[1];
				end
				DTC_REG_SCFG: rbyte = st_ff.sys_cfg;
				DTC_REG_TMODE: rbyte = st_ff.tmode;
				DTC_REG_CNT_LO: rbyte = st_ff.count_low_byte[ti];
				DTC_REG_CNT_HI: rbyte = st_ff.count_high_byte[ti];
				DTC_REG_RLD_LO: rbyte = st_ff.reload_low_byte[ti];
				DTC_REG_RLD_HI: rbyte = st_ff.reload_high_byte[ti];
				default: rbyte = 8'h00;
			endcase
			nxt_st.rdata = {24'h000000, rbyte};
			nxt_st.err = (rsel == DTC_REG_NONE);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
			st_ff.sys_cfg <= SYS_CFG_RESET;
			st_ff.tmode <= TIMER_MODE_RESET;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign pready = psel && penable;
	assign prdata = st_ff.rdata;
	assign pslverr = psel && penable && st_ff.err;
	assign overflow_flag = st_ff.flag;
endmodule // dtc_top

//--- tb/dtc_pin_model.sv
`timescale 1ns/1ps
module dtc_pin_model (
	input wire logic pclk,
	output logic [1:0] event_input_pin,
	output logic [1:0] ext_int_pin
);
	initial begin
		event_input_pin = 2'b11;
		ext_int_pin = 2'b11;
	end
	// Each level held two clocks
	task pulse(input int n, input int cnt);
		repeat (cnt) begin
			@(posedge pclk);
			event_input_pin[n] <= 1'b0;
			repeat (2) @(posedge pclk);
			event_input_pin[n] <= 1'b1;
			@(posedge pclk);
		end
	endtask
	task gate(input int n, input logic v);
		@(posedge pclk);
		ext_int_pin[n] <= v;
	endtask
endmodule // dtc_pin_model

//--- tb/dtc_top_checker.sv
`timescale 1ns/1ps
module dtc_top_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [1:0] event_input_pin,
	input wire logic [1:0] ext_int_pin,
	input wire logic [1:0] overflow_flag
);
	import dtc_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic mapped;
	assign mapped = paddr inside {ADDR_TIMER_CTRL, ADDR_SYS_CFG, ADDR_TIMER_MODE, ADDR_CNT0_LO,
		ADDR_CNT0_HI, ADDR_CNT1_LO, ADDR_CNT1_HI, ADDR_RLD0_LO, ADDR_RLD0_HI, ADDR_RLD1_LO,
		ADDR_RLD1_HI};
	sequence s_acc;
		psel && penable;
	endsequence
	sequence s_wr_ctrl;
		s_acc ##0 pwrite && paddr == ADDR_TIMER_CTRL;
	endsequence
	////////////////////////////////
	pready_on_a: assert property (s_acc |-> pready) else $error("pready low in access");
	pready_off_a: assert property (!(psel && penable) |-> !pready && !pslverr)
		else $error("response outside access");
	err_unmapped_a: assert property (s_acc ##0 !mapped |-> pslverr) else $error("no error");
	err_mapped_a: assert property (s_acc ##0 mapped |-> !pslverr) else $error("false error");
	rdata_upper_a: assert property (s_acc |-> prdata[31:8] == 24'h0) else $error("upper bits");
	rdata_hold_a: assert property (s_acc ##1 !psel |-> $stable(prdata)) else $error("prdata moved");
	flags_reset_a: assert property ($rose(presetn) |-> overflow_flag == 2'b00)
		else $error("flag after reset");
	flag_clear_a: assert property ((($past(overflow_flag) & ~overflow_flag) != 2'b00) |->
		$past(psel && penable && pwrite && paddr == ADDR_TIMER_CTRL)) else $error("flag fell");
	cover property (s_wr_ctrl);
endmodule // dtc_top_checker

bind dtc_top dtc_top_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .event_input_pin(event_input_pin),
	.ext_int_pin(ext_int_pin), .overflow_flag(overflow_flag));

//--- tb/test_dual_timer_counter_reload.sv
`timescale 1ns/1ps
module test_dual_timer_counter_reload;
	import dtc_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [1:0] event_input_pin, ext_int_pin, overflow_flag;
	logic [7:0] rd;
	int fails, num_checks, cyc, t1;
	dtc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .event_input_pin(event_input_pin), .ext_int_pin(ext_int_pin),
		.overflow_flag(overflow_flag));
	dtc_pin_model u_pins (.pclk(pclk), .event_input_pin(event_input_pin),
		.ext_int_pin(ext_int_pin));
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	always @(posedge pclk) cyc <= cyc + 1;
	////////////////////////////////
	task wrap_up;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 50) begin
			fails++;
			wrap_up;
		end
		rd = prdata[7:0];
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [11:0] a, input logic [7:0] d);
		xfer(1'b1, a, d);
	endtask
	task rchk(input logic [11:0] a, input logic [7:0] exp);
		xfer(1'b0, a, 8'h00);
		chk({8'h0, rd}, {8'h0, exp});
	endtask
	task wait_flag(input int n);
		int i;
		for (i = 0; i < 3000; i++) begin
			@(negedge pclk);
			if (overflow_flag[n] === 1'b1) break;
		end
		if (i == 3000) begin
			fails++;
			wrap_up;
		end
	endtask
	task interval(input int n, input logic [7:0] run);
		wr(ADDR_TIMER_CTRL, run);
		wait_flag(n);
		t1 = cyc;
		wr(ADDR_TIMER_CTRL, run);
		wait_flag(n);
	endtask
	////////////////////////////////
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		fails = 0;
		num_checks = 0;
		cyc = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rchk(ADDR_TIMER_CTRL, TIMER_CTRL_RESET);
		rchk(ADDR_SYS_CFG, SYS_CFG_RESET);
		rchk(ADDR_TIMER_MODE, TIMER_MODE_RESET);
		xfer(1'b0, 12'h400, 8'h00);
		chk({15'h0, er}, 16'h0001);
		wr(ADDR_SYS_CFG, 8'hF7);
		rchk(ADDR_SYS_CFG, 8'hF7 & SYS_CFG_MASK);
		for (int k = 0; k < 4; k++) wr(ADDR_RLD0_LO + 12'(4 * k), 8'(8'h21 * k + 1));
		for (int k = 0; k < 4; k++) rchk(ADDR_RLD0_LO + 12'(4 * k), 8'(8'h21 * k + 1));
		$display("test registers done");
		for (int n = 0; n < 2; n++) begin
			for (int p = 0; p < 3; p++) begin
				wr(ADDR_TIMER_CTRL, 8'h00);
				wr(ADDR_SYS_CFG, 8'(p << PRESCALE_LSB));
				wr(ADDR_TIMER_MODE, 8'h00);
				wr(ADDR_RLD0_LO + 12'(8 * n), 8'hF0);
				wr(ADDR_RLD0_HI + 12'(8 * n), 8'hFF);
				wr(ADDR_CNT0_LO + 12'(8 * n), 8'hF0);
				wr(ADDR_CNT0_HI + 12'(8 * n), 8'hFF);
				interval(n, 8'(8'h10 << (2 * n)));
				chk(16'(cyc - t1), 16'(64 << (2 * p)));
				rchk(ADDR_CNT0_HI + 12'(8 * n), 8'hFF);
			end
		end
		$display("test reload done");
		wr(ADDR_TIMER_CTRL, 8'h00);
		wr(ADDR_SYS_CFG, 8'h00);
		wr(ADDR_TIMER_MODE, {6'h0, MODE_8_RELOAD});
		wr(ADDR_RLD0_LO, 8'hFC);
		wr(ADDR_CNT0_HI, 8'h5A);
		wr(ADDR_CNT0_LO, 8'hFC);
		interval(0, 8'h10);
		chk(16'(cyc - t1), 16'd16);
		rchk(ADDR_CNT0_HI, 8'h5A);
		wr(ADDR_TIMER_CTRL, 8'h00);
		wr(ADDR_TIMER_MODE, {6'h0, MODE_16_FREE});
		wr(ADDR_CNT0_LO, 8'hFC);
		wr(ADDR_CNT0_HI, 8'hFF);
		wr(ADDR_TIMER_CTRL, 8'h10);
		wait_flag(0);
		rchk(ADDR_CNT0_HI, 8'h00);
		rchk(ADDR_TIMER_CTRL, 8'h30);
		$display("test modes done");
		wr(ADDR_TIMER_CTRL, 8'h00);
		wr(ADDR_TIMER_MODE, 8'h0C);
		wr(ADDR_CNT0_LO, 8'h00);
		u_pins.gate(0, 1'b0);
		wr(ADDR_TIMER_CTRL, 8'h10);
		u_pins.pulse(0, 3);
		repeat (8) @(posedge pclk);
		rchk(ADDR_CNT0_LO, 8'h00);
		u_pins.gate(0, 1'b1);
		u_pins.pulse(0, 3);
		repeat (8) @(posedge pclk);
		rchk(ADDR_CNT0_LO, 8'h03);
		wr(ADDR_TIMER_CTRL, 8'h00);
		wr(ADDR_TIMER_MODE, 8'h30);
		wr(ADDR_CNT1_LO, 8'h42);
		wr(ADDR_TIMER_CTRL, 8'h40);
		repeat (100) @(posedge pclk);
		rchk(ADDR_CNT1_LO, 8'h42);
		wr(ADDR_TIMER_CTRL, 8'h00);
		wr(ADDR_TIMER_MODE, 8'h33);
		wr(ADDR_CNT0_LO, 8'h77);
		wr(ADDR_CNT0_HI, 8'hFC);
		wr(ADDR_TIMER_CTRL, 8'h40);
		wait_flag(1);
		rchk(ADDR_CNT0_HI, 8'h00);
		rchk(ADDR_TIMER_CTRL, 8'hC0);
		rchk(ADDR_CNT0_LO, 8'h77);
		rchk(ADDR_CNT1_LO, 8'h42);
		$display("test events done");
		wrap_up;
	end
endmodule // test_dual_timer_counter_reload
